// >>> rtl/rsd_defines.svh
// Register offsets, field positions and reset values of the Rf_link_status bank
`ifndef RSD_DEFINES_SVH
`define RSD_DEFINES_SVH

// Printed offsets are word indices; byte address is four times the index
`define RSD_IDX_SIGPRO 8'h1C
`define RSD_IDX_STATUS 8'h1D
`define RSD_ADR_SIGPRO 10'h070
`define RSD_ADR_STATUS 10'h074

`define RSD_SP_GRID_BIT 2
`define RSD_SP_FSK_BIT 1
`define RSD_SP_PSK_BIT 0
`define RSD_SP_GRID_RST 1'h0
`define RSD_SP_PSK_RST 1'h0
`define RSD_SP_FSK_VAL 1'h0

`define RSD_ST_SEQ_LSB 24
`define RSD_ST_STEP_LSB 20
`define RSD_ST_LOOP_BIT 19
`define RSD_ST_CRC_BIT 18
`define RSD_ST_OWN_BIT 17
`define RSD_ST_EXT_BIT 16
`define RSD_ST_ERR_LSB 13
`define RSD_ST_RXEN_BIT 12
`define RSD_ST_TXACT_BIT 11
`define RSD_ST_RXACT_BIT 10
`define RSD_ST_GAIN_LSB 0

`define RSD_CRC_RESIDUE 16'h0000

`endif

// >>> rtl/rsd_pkg.sv
// Types shared by the Rf_link_status and demodulation configuration bank
package rsd_pkg;
   typedef enum logic [2:0] {
      RSD_SEQ_IDLE,
      RSD_SEQ_WAIT_TX,
      RSD_SEQ_TX,
      RSD_SEQ_WAIT_RX,
      RSD_SEQ_WAIT_DATA,
      RSD_SEQ_RX,
      RSD_SEQ_LOOPBACK,
      RSD_SEQ_RSVD
   } rsd_seq_state_t;

   typedef enum logic [2:0] {
      RSD_ERR_NONE,
      RSD_ERR_EXT_INIT_WIN,
      RSD_ERR_EXT_ACT_WIN,
      RSD_ERR_NO_EXT_ACT_WIN,
      RSD_ERR_PEER_DROP,
      RSD_ERR_RSVD5,
      RSD_ERR_RSVD6,
      RSD_ERR_RSVD7
   } rsd_err_code_t;

   typedef struct packed {
      logic ack;
      logic [31:0] dat;
      logic bit_grid_at_max;
      logic phase_shift_demod_select;
      rsd_err_code_t active_mode_error_code;
   } rsd_state_t;
endpackage

// >>> rtl/rsd_status_bank.sv
// Wishbone register bank: demod config bits and live Rf_link_status word
//
// Chosen here: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
`include "rsd_defines.svh"

module rsd_status_bank #(
   parameter int CRC_W = 16,
   parameter int GAIN_W = 10
) (
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone classic slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [9:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // Live status sources from the transceive datapath
   input wire rsd_pkg::rsd_seq_state_t seq_state_i,
   input wire logic [3:0] power_control_step_i,
   input wire logic field_on_i,
   input wire logic rf_freq_ok_i,
   input wire logic pll_locked_i,
   input wire logic [CRC_W-1:0] crc_reg_i,
   input wire logic crc_inverted_i,
   input wire logic own_field_on_i,
   input wire logic external_field_seen_i,
   input wire logic active_mode_error_event_i,
   input wire rsd_pkg::rsd_err_code_t active_mode_error_code_i,
   input wire logic field_driver_enable_set_i,
   input wire logic rx_decoder_armed_i,
   input wire logic tx_busy_i,
   input wire logic rx_busy_i,
   input wire logic [GAIN_W-1:0] gain_control_level_i,
   // Config outputs
   output logic bit_grid_at_max_o,
   output logic phase_shift_demod_select_o,
   output logic freq_shift_demod_select_o,
   output logic [GAIN_W-1:0] rx_resistor_enable_o
);
   import rsd_pkg::*;

   // ---------------------------------------------------------------
   // Field widths
   // ---------------------------------------------------------------
   // Fixed by the register map; only CRC and gain widths may vary
   localparam int SEQ_W = 3;
   localparam int STEP_W = 4;
   localparam int ERR_W = 3;

   // ---------------------------------------------------------------
   // Helper functions
   // ---------------------------------------------------------------
   // Config word sits in the first of the two word slots
   function automatic logic is_cfg_adr(input logic [9:0] adr);
      return adr == `RSD_ADR_SIGPRO;
   endfunction

   // Status word sits in the slot after the config word
   function automatic logic is_status_adr(input logic [9:0] adr);
      return adr == `RSD_ADR_STATUS;
   endfunction

   // Every writable config bit lives in byte lane 0
   function automatic logic cfg_lane_on(input logic [3:0] sel);
      return sel[0];
   endfunction

   // Good check-sum: zero, or the residue when the CRC is inverted
   function automatic logic crc_passes(
      input logic [CRC_W-1:0] crc,
      input logic inverted
   );
      logic [CRC_W-1:0] target;
      target = '0;
      if (inverted) begin
         target = CRC_W'(`RSD_CRC_RESIDUE);
      end
      return crc == target;
   endfunction

   // Loop runs only with field on, frequency valid and PLL locked
   function automatic logic loop_runs(
      input logic field_on,
      input logic freq_ok,
      input logic locked
   );
      return field_on & freq_ok & locked;
   endfunction

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   rsd_state_t s_q;
   rsd_state_t s_d;
   logic [31:0] status_word;
   logic [31:0] config_word;
   logic [31:0] read_word;
   logic loop_enabled;
   logic crc_good;
   logic req;
   logic rd_req;
   logic wr_req;
   logic wr_cfg;
   logic cause_set;
   logic cause_clear;
   rsd_err_code_t cause_next;

   // ---------------------------------------------------------------
   // Live status terms
   // ---------------------------------------------------------------
   assign loop_enabled = loop_runs(field_on_i, rf_freq_ok_i,
      pll_locked_i);

   // Meaningful only after the frame ends; mid-frame value is transient
   assign crc_good = crc_passes(crc_reg_i, crc_inverted_i);

   // ---------------------------------------------------------------
   // Status word assembly
   // ---------------------------------------------------------------
   // Unlisted bits stay zero, so reserved bits read back as zero
   always_comb begin
      status_word = 32'h0000_0000;

      // Sequencer state; the reserved code is passed through as is
      status_word[`RSD_ST_SEQ_LSB +: SEQ_W] = seq_state_i;

      // Step currently applied by the power control loop
      status_word[`RSD_ST_STEP_LSB +: STEP_W] =
         power_control_step_i;

      status_word[`RSD_ST_LOOP_BIT] = loop_enabled;

      status_word[`RSD_ST_CRC_BIT] = crc_good;

      // Field presence, own and external, both passed live
      status_word[`RSD_ST_OWN_BIT] = own_field_on_i;
      status_word[`RSD_ST_EXT_BIT] = external_field_seen_i;

      // Held cause, not the live code: valid across the error event
      status_word[`RSD_ST_ERR_LSB +: ERR_W] =
         s_q.active_mode_error_code;

      // Decoder and encoder activity
      status_word[`RSD_ST_RXEN_BIT] = rx_decoder_armed_i;
      status_word[`RSD_ST_TXACT_BIT] = tx_busy_i;
      status_word[`RSD_ST_RXACT_BIT] = rx_busy_i;

      // Gain level, zero is the most sensitive setting
      status_word[`RSD_ST_GAIN_LSB +: GAIN_W] =
         gain_control_level_i;
   end

   // ---------------------------------------------------------------
   // Config word assembly
   // ---------------------------------------------------------------
   always_comb begin
      config_word = 32'h0000_0000;
      config_word[`RSD_SP_GRID_BIT] = s_q.bit_grid_at_max;
      // Frequency-shift demodulation is not built, so the bit is fixed
      config_word[`RSD_SP_FSK_BIT] = `RSD_SP_FSK_VAL;
      config_word[`RSD_SP_PSK_BIT] = s_q.phase_shift_demod_select;
   end

   // ---------------------------------------------------------------
   // Read data select
   // ---------------------------------------------------------------
   // Unmapped reads return zero rather than aliasing a register
   always_comb begin
      read_word = 32'h0000_0000;
      if (is_cfg_adr(adr_i)) begin
         read_word = config_word;
      end else if (is_status_adr(adr_i)) begin
         // Status sampled at the read, no snapshot held
         read_word = status_word;
      end
   end

   // ---------------------------------------------------------------
   // Bus request decode
   // ---------------------------------------------------------------
   // Ack blocks the cycle after a take, so one strobe is one access
   assign req = cyc_i & stb_i & ~s_q.ack;
   assign rd_req = req & ~we_i;
   assign wr_req = req & we_i;

   // Writes to the status word or unmapped slots fall through
   assign wr_cfg = wr_req & cfg_lane_on(sel_i) & is_cfg_adr(adr_i);

   // ---------------------------------------------------------------
   // Error cause hold
   // ---------------------------------------------------------------
   assign cause_set = active_mode_error_event_i;
   assign cause_clear = field_driver_enable_set_i;

   // A new error event wins over a driver-enable clear in one cycle
   always_comb begin
      cause_next = s_q.active_mode_error_code;
      if (cause_clear) begin
         cause_next = RSD_ERR_NONE;
      end
      if (cause_set) begin
         cause_next = active_mode_error_code_i;
      end
   end

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      s_d.ack = req;
      if (rd_req) begin
         s_d.dat = read_word;
      end
      if (wr_cfg) begin
         s_d.bit_grid_at_max = dat_i[`RSD_SP_GRID_BIT];
         s_d.phase_shift_demod_select = dat_i[`RSD_SP_PSK_BIT];
      end
      s_d.active_mode_error_code = cause_next;
      // Reset last so it overrides any request in the same cycle
      if (rst_i) begin
         s_d.ack = 1'b0;
         s_d.dat = 32'h0000_0000;
         s_d.bit_grid_at_max = `RSD_SP_GRID_RST;
         s_d.phase_shift_demod_select = `RSD_SP_PSK_RST;
         s_d.active_mode_error_code = RSD_ERR_NONE;
      end
   end

   // ---------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      s_q <= s_d;
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign ack_o = s_q.ack;
   assign dat_o = s_q.dat;
   assign bit_grid_at_max_o = s_q.bit_grid_at_max;
   assign phase_shift_demod_select_o = s_q.phase_shift_demod_select;
   assign freq_shift_demod_select_o = `RSD_SP_FSK_VAL;
   // Each set bit adds one resistor in parallel: more bits, less gain
   assign rx_resistor_enable_o = gain_control_level_i;
endmodule

`default_nettype wire

// >>> testbench/rsd_status_checker.sv
// Checker for bus timing and the live status word
`timescale 1ns/1ps
`default_nettype none
module rsd_status_checker
   import rsd_pkg::*;
#(parameter int CRC_W = 16, parameter int GAIN_W = 10) (
   input wire logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o,
   input wire logic [9:0] adr_i,
   input wire logic [31:0] dat_o,
   input wire rsd_seq_state_t seq_state_i,
   input wire logic field_on_i, rf_freq_ok_i, pll_locked_i,
   input wire logic [CRC_W-1:0] crc_reg_i,
   input wire logic [GAIN_W-1:0] gain_control_level_i, rx_resistor_enable_o,
   input wire logic freq_shift_demod_select_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // Status read taken at this edge
   wire logic rd = cyc_i && stb_i && !ack_o && !we_i
      && adr_i == 10'h074;
   ack_pulse_a:
      assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
      else $error("ack timing");
   seq_field_a:
      assert property (rd |=> dat_o[26:24] == $past(seq_state_i))
      else $error("seq");
   loop_bit_a:
      assert property (rd |=> dat_o[19] == $past(field_on_i && rf_freq_ok_i
         && pll_locked_i)) else $error("loop");
   crc_good_a:
      assert property (rd |=> dat_o[18] == ($past(crc_reg_i) == '0))
      else $error("crc");
   gain_field_a:
      assert property (rd |=> dat_o[9:0] == $past(gain_control_level_i))
      else $error("gain");
   rsvd_zero_a:
      assert property (rd |=> dat_o[31:27] == 5'h00) else $error("rsvd");
   fsk_zero_a:
      assert property (freq_shift_demod_select_o == 1'b0) else $error("fsk");
   resistor_map_a:
      assert property (rx_resistor_enable_o == gain_control_level_i)
      else $error("resistors");
endmodule
bind rsd_status_bank rsd_status_checker #(.CRC_W(CRC_W), .GAIN_W(GAIN_W)) chk_u (.*);
`default_nettype wire

// >>> testbench/tb.sv
// Self-checking bench for the Rf_link_status bank
`timescale 1ns/1ps
`default_nettype none
module tb;
   import rsd_pkg::*;
   logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, field_on_i, rf_freq_ok_i;
   logic pll_locked_i, crc_inverted_i, own_field_on_i, external_field_seen_i;
   logic active_mode_error_event_i, field_driver_enable_set_i, tx_busy_i;
   logic rx_decoder_armed_i, rx_busy_i, bit_grid_at_max_o;
   logic phase_shift_demod_select_o, freq_shift_demod_select_o;
   logic [9:0] adr_i, gain_control_level_i, rx_resistor_enable_o;
   logic [3:0] sel_i, power_control_step_i;
   logic [31:0] dat_i, dat_o, r;
   logic [15:0] crc_reg_i;
   rsd_seq_state_t seq_state_i;
   rsd_err_code_t active_mode_error_code_i;
   int bad_count = 0;
   int total_checks = 0;
   rsd_status_bank dut_u (.*);
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("Error %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   // Holds the request until ack is sampled; a lost ack counts as a mismatch
   task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d);
      int n;
      n = 0;
      {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'h3, w, a, d, 4'hF};
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 20);
      r = dat_o;
      if (n >= 20) bad_count++;
      {cyc_i, stb_i} <= 2'h0;
      @(posedge clk_i);
   endtask
   task automatic wrap_up;
      if (bad_count == 0 && total_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic t_config;
      bus(1'b1, 10'h070, 32'hFFFFFFFF);
      bus(1'b0, 10'h070, 32'h0);
      chk(r, 32'h00000005);
      chk({bit_grid_at_max_o, phase_shift_demod_select_o}, 32'h3);
      bus(1'b1, 10'h070, 32'h0);
      chk({bit_grid_at_max_o, phase_shift_demod_select_o}, 32'h0);
   endtask
   task automatic t_status;
      for (int i = 0; i < 8; i++) begin
         seq_state_i <= rsd_seq_state_t'(i);
         {power_control_step_i, field_on_i, rf_freq_ok_i, pll_locked_i,
            own_field_on_i, external_field_seen_i, rx_decoder_armed_i,
            tx_busy_i, rx_busy_i} <= 12'(i * 12'h9D3);
         gain_control_level_i <= 10'(i * 10'h249);
         crc_reg_i <= i[0] ? 16'h0000 : 16'h8005;
         crc_inverted_i <= i[1];
         bus(1'b1, 10'h074, 32'hFFFFFFFF);
         bus(1'b0, 10'h074, 32'h0);
         chk(r, {5'h00, seq_state_i, power_control_step_i, field_on_i
            & rf_freq_ok_i & pll_locked_i, crc_reg_i == 16'h0000,
            own_field_on_i, external_field_seen_i, 3'h0, rx_decoder_armed_i,
            tx_busy_i, rx_busy_i, gain_control_level_i});
      end
   endtask
   task automatic t_error;
      for (int c = 1; c < 5; c++) begin
         active_mode_error_code_i <= rsd_err_code_t'(c);
         active_mode_error_event_i <= 1'b1;
         @(posedge clk_i);
         active_mode_error_event_i <= 1'b0;
         bus(1'b0, 10'h074, 32'h0);
         chk(r[15:13], 32'(c));
         field_driver_enable_set_i <= 1'b1;
         @(posedge clk_i);
         field_driver_enable_set_i <= 1'b0;
         bus(1'b0, 10'h074, 32'h0);
         chk(r[15:13], 32'h0);
      end
      active_mode_error_code_i <= RSD_ERR_EXT_ACT_WIN;
      {active_mode_error_event_i, field_driver_enable_set_i} <= 2'h3;
      @(posedge clk_i);
      {active_mode_error_event_i, field_driver_enable_set_i} <= 2'h0;
      bus(1'b0, 10'h074, 32'h0);
      chk(r[15:13], 32'h2);
   endtask
   // Mid-run reset must restore config defaults and clear the cause
   task automatic t_reset;
      bus(1'b1, 10'h070, 32'h00000005);
      active_mode_error_code_i <= RSD_ERR_PEER_DROP;
      active_mode_error_event_i <= 1'b1;
      @(posedge clk_i);
      active_mode_error_event_i <= 1'b0;
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      bus(1'b0, 10'h070, 32'h0);
      chk(r, 32'h0);
      chk({bit_grid_at_max_o, phase_shift_demod_select_o}, 32'h0);
      bus(1'b0, 10'h074, 32'h0);
      chk(r[15:13], 32'h0);
   endtask
   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end
   initial begin
      #100000;
      bad_count++;
      wrap_up;
   end
   initial begin
      rst_i = 1'b1;
      {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i, gain_control_level_i} = '0;
      {power_control_step_i, field_on_i, rf_freq_ok_i, pll_locked_i} = '0;
      {own_field_on_i, external_field_seen_i, rx_decoder_armed_i} = '0;
      {tx_busy_i, rx_busy_i, crc_inverted_i, active_mode_error_event_i} = '0;
      field_driver_enable_set_i = 1'b0;
      seq_state_i = RSD_SEQ_IDLE;
      active_mode_error_code_i = RSD_ERR_NONE;
      crc_reg_i = 16'hFFFF;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      bus(1'b0, 10'h3FC, 32'h0);
      chk(r, 32'h0);
      bus(1'b0, 10'h074, 32'h0);
      chk(r, 32'h0);
      bus(1'b0, 10'h070, 32'h0);
      chk(r, 32'h0);
      t_config;
      t_status;
      t_error;
      t_reset;
      wrap_up;
   end
endmodule
`default_nettype wire
